// file: hw/spa_regs.svh
/*
 * Register offsets, field positions, reset values and codes of the
 * slave port priority and fault source block.
 * Assumes it is included by bare name; holds definitions only.
 */
`ifndef SPA_REGS_SVH
`define SPA_REGS_SVH

// ----------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------
`define SPA_OFS_CTRL 8'h00
`define SPA_OFS_FAULT 8'h04
`define SPA_OFS_IRQST 8'h08
`define SPA_OFS_IRQMSK 8'h0c

// ----------------------------------------------------------------
// Priority control register fields
// ----------------------------------------------------------------
`define SPA_CTL_RNG 1:0
`define SPA_THR_RNG 10:2
`define SPA_THR_CODE_RNG 9:2
`define SPA_INIT_RNG 15:11
`define SPA_CTRL_RST 16'h0800
`define SPA_CTL_SLV_DEM 2'h0
`define SPA_CTL_SW_DEM 2'h1
`define SPA_CTL_THRESH 2'h2
`define SPA_CTL_EXTPIN 2'h3
`define SPA_CNT_RST 5'h01
`define SPA_CNT_RR 5'h01
`define SPA_THR_HARDFAULT 8'hff
`define SPA_THR_NMI 8'hfe
`define SPA_RANK_NMI 9'h000
`define SPA_RANK_HARDFAULT 9'h001
`define SPA_RANK_OFS 9'h002

// ----------------------------------------------------------------
// Fault source register fields
// ----------------------------------------------------------------
`define SPA_FLT_INSTR_MEM 0
`define SPA_FLT_DATA_MEM 1
`define SPA_FLT_PERIPH 2
`define SPA_FLT_MAIN 3
`define SPA_FLT_EPPORT 4
`define SPA_FLT_RNG 4:0
`define SPA_FRESP_RNG 9:8

// ----------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------
`define SPA_RESP_OKAY 2'h0
`define SPA_RESP_SLVERR 2'h2

`endif

// file: hw/spa_pkg.sv
/*
 * Types shared by the slave port priority block and its bench.
 * Assumes the AXI4-Lite slave carries 32-bit data and 8-bit addresses.
 */
package spa_pkg;

    // ------------------------------------------------------------
    // Register bus carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } spa_axil_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } spa_axil_rsp_type;

    // ------------------------------------------------------------
    // Whole state of the block
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] ctrl;
        logic [4:0] flt;
        logic [1:0] fresp;
        logic [4:0] irq_pend;
        logic [4:0] irq_msk;
        logic [4:0] cnt;
        logic sw_gnt;
        logic slv_gnt;
        logic irq;
        logic aw_held;
        logic [7:0] awaddr;
        logic w_held;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        spa_axil_rsp_type rsp;
    } spa_state_type;

endpackage

// file: hw/spa_top.sv
/*
 * Arbitration between the processor's software accesses and the slave
 * port, with the fairness counter and execution priority threshold,
 * plus the asynchronous bus fault source flags and their interrupt.
 * Assumes requests and fault pulses are synchronous to SYS_CLK_I and
 * an AXI4-Lite master that keeps the usual valid/ready rules.
 */
// Operation
// [RULE_01] Control bits 1:0 reset to 0, slave port loses contention then.
// [RULE_02] Control value 1 demotes software so slave port wins contention.
// [RULE_03] Value 2 with priority at or above threshold reloads counter with initial value.
// [RULE_04] Value 2 with priority below threshold reloads counter with one.
// [RULE_05] Value 3 hands the decision to the external slave priority input.
// [RULE_06] Fairness initial value is ignored while control holds 3.
// [RULE_07] Initial value lives in bits 15:11, read-write, resets to one.
// [RULE_08] Software must not program initial value zero, livelock risk.
// [RULE_09] Software should use initial value one with control 0 or 1.
// [RULE_10] Threshold in bits 10:2; top code bit clear means plain priority. The code ignores bit 10 and ranks bits 9:2 only.
// [RULE_11] Code 0xff means priority -1, code 0xfe means priority -2.
// [RULE_12] Numerically larger priority value means lower priority in comparisons.
// [RULE_13] Fault flags: bit0 instruction memory, 1 data memory, 2 peripheral, 3 main, 4 external.
// [RULE_14] Bits 9:8 hold main port fault response, valid while its flag set.
// [RULE_15] Any write to the fault register clears flags 4:0.
// [RULE_16] Handler reads general fault status first, then this register.
// [RULE_17] Each fault pulse sets its flag, accumulating until cleared.
// [RULE_18] Counter decrements per favoured win; at zero demoted wins, reload.
`timescale 1ns/1ps
`include "spa_regs.svh"

module spa_top (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire spa_pkg::spa_axil_req_type AXI_REQ_I,
    output spa_pkg::spa_axil_rsp_type AXI_RSP_O,
    input wire logic SW_REQ_I,
    input wire logic SLV_REQ_I,
    input wire logic [7:0] EXEC_PRI_I,
    input wire logic EXT_SLV_PRI_I,
    output logic SW_GNT_O,
    output logic SLV_GNT_O,
    input wire logic [4:0] FAULT_EV_I,
    input wire logic [1:0] FAULT_RESP_I,
    output logic IRQ_O
);
    import spa_pkg::*;

    spa_state_type s_q;
    spa_state_type s_d;
    logic [1:0] ctl;
    logic [4:0] init_val;
    logic [4:0] reload;
    logic sw_hi;
    logic fav_slv;
    logic both;
    logic do_wr;
    logic wr_fault;
    logic [4:0] irq_clr;
    logic [31:0] rd_val;
    logic rd_hit;

    // ------------------------------------------------------------
    // Priority ranks
    // ------------------------------------------------------------
    // Ranks put the two negative codes below every plain priority so a
    // single unsigned compare orders all codes, larger meaning lower.
    function automatic logic [8:0] spa_rank(input logic [7:0] c);
        if (c == `SPA_THR_NMI) begin
            return `SPA_RANK_NMI; // RULE_11
        end
        if (c == `SPA_THR_HARDFAULT) begin
            return `SPA_RANK_HARDFAULT; // RULE_11
        end
        return {1'b0, c} + `SPA_RANK_OFS; // RULE_10
    endfunction

    assign ctl = s_q.ctrl[`SPA_CTL_RNG];
    assign init_val = s_q.ctrl[`SPA_INIT_RNG];
    assign both = SW_REQ_I & SLV_REQ_I;

    // Software priority at or above threshold means a rank not larger.
    assign sw_hi = spa_rank(EXEC_PRI_I) <= spa_rank(s_q.ctrl[`SPA_THR_CODE_RNG]); // RULE_12

    // ------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        case (AXI_REQ_I.araddr)
            `SPA_OFS_CTRL: begin
                rd_val = {16'h0000, s_q.ctrl};
            end
            `SPA_OFS_FAULT: begin
                rd_val[`SPA_FLT_RNG] = s_q.flt; // RULE_13
                rd_val[`SPA_FRESP_RNG] = s_q.fresp; // RULE_14
            end
            `SPA_OFS_IRQST: begin
                rd_val = {27'h0000000, s_q.irq_pend};
            end
            `SPA_OFS_IRQMSK: begin
                rd_val = {27'h0000000, s_q.irq_msk};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        fav_slv = 1'b0;
        reload = init_val;
        do_wr = 1'b0;
        wr_fault = 1'b0;
        irq_clr = 5'h00;

        // Arbitration: decide the favoured requestor for this mode.
        unique case (ctl)
            `SPA_CTL_SLV_DEM: begin
                fav_slv = 1'b0; // RULE_01
            end
            `SPA_CTL_SW_DEM: begin
                fav_slv = 1'b1; // RULE_02
            end
            `SPA_CTL_THRESH: begin
                fav_slv = 1'b0;
                if (sw_hi) begin
                    reload = init_val; // RULE_03
                end else begin
                    reload = `SPA_CNT_RR; // RULE_04
                end
            end
            `SPA_CTL_EXTPIN: begin
                fav_slv = EXT_SLV_PRI_I; // RULE_05
            end
        endcase

        s_d.sw_gnt = SW_REQ_I;
        s_d.slv_gnt = SLV_REQ_I;
        if (both) begin
            if (ctl == `SPA_CTL_EXTPIN) begin
                // Counter and initial value play no part here.
                s_d.sw_gnt = ~fav_slv; // RULE_06
                s_d.slv_gnt = fav_slv;
            end else if (s_q.cnt == 5'h00) begin
                s_d.sw_gnt = fav_slv; // RULE_18
                s_d.slv_gnt = ~fav_slv;
                s_d.cnt = reload;
            end else begin
                s_d.sw_gnt = ~fav_slv;
                s_d.slv_gnt = fav_slv;
                s_d.cnt = 5'(s_q.cnt - 5'h01); // RULE_18
            end
        end

        // Write address and data are taken in either order.
        if (AXI_REQ_I.awvalid && s_q.rsp.awready) begin
            s_d.aw_held = 1'b1;
            s_d.awaddr = AXI_REQ_I.awaddr;
        end
        if (AXI_REQ_I.wvalid && s_q.rsp.wready) begin
            s_d.w_held = 1'b1;
            s_d.wdata = AXI_REQ_I.wdata;
            s_d.wstrb = AXI_REQ_I.wstrb;
        end
        if (s_q.rsp.bvalid && AXI_REQ_I.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        if (s_q.aw_held && s_q.w_held && !s_q.rsp.bvalid) begin
            do_wr = 1'b1;
            s_d.aw_held = 1'b0;
            s_d.w_held = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = `SPA_RESP_OKAY;
            case (s_q.awaddr)
                `SPA_OFS_CTRL: begin
                    if (s_q.wstrb[0]) begin
                        s_d.ctrl[7:0] = s_q.wdata[7:0];
                    end
                    if (s_q.wstrb[1]) begin
                        s_d.ctrl[15:8] = s_q.wdata[15:8]; // RULE_07
                    end
                end
                `SPA_OFS_FAULT: begin
                    // Data and strobes do not matter for this clear.
                    wr_fault = 1'b1; // RULE_15
                end
                `SPA_OFS_IRQST: begin
                    if (s_q.wstrb[0]) begin
                        irq_clr = s_q.wdata[4:0];
                    end
                end
                `SPA_OFS_IRQMSK: begin
                    if (s_q.wstrb[0]) begin
                        s_d.irq_msk = s_q.wdata[4:0];
                    end
                end
                default: begin
                    s_d.rsp.bresp = `SPA_RESP_SLVERR;
                end
            endcase
        end
        s_d.rsp.awready = ~s_d.aw_held;
        s_d.rsp.wready = ~s_d.w_held;

        // Read channel: one read under way at a time.
        if (s_q.rsp.rvalid && AXI_REQ_I.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (AXI_REQ_I.arvalid && s_q.rsp.arready) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata = rd_val;
            s_d.rsp.rresp = rd_hit ? `SPA_RESP_OKAY : `SPA_RESP_SLVERR;
        end
        s_d.rsp.arready = ~s_d.rsp.rvalid;

        // Fault flags: a pulse in the clearing cycle survives the clear.
        if (wr_fault) begin
            s_d.flt = 5'h00;
        end
        s_d.flt = s_d.flt | FAULT_EV_I; // RULE_17
        if (FAULT_EV_I[`SPA_FLT_MAIN]) begin
            s_d.fresp = FAULT_RESP_I; // RULE_14
        end
        s_d.irq_pend = (s_q.irq_pend & ~irq_clr) | FAULT_EV_I;
        s_d.irq = |(s_d.irq_pend & s_d.irq_msk);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s_q <= '0;
            s_q.ctrl <= `SPA_CTRL_RST; // RULE_01
            s_q.cnt <= `SPA_CNT_RST;
            s_q.rsp.awready <= 1'b1;
            s_q.rsp.wready <= 1'b1;
            s_q.rsp.arready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign AXI_RSP_O = s_q.rsp;
    assign SW_GNT_O = s_q.sw_gnt;
    assign SLV_GNT_O = s_q.slv_gnt;
    assign IRQ_O = s_q.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_MODE0_SW_WINS: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_01
        (both && ctl == `SPA_CTL_SLV_DEM && s_q.cnt != 5'h00)
        |=> (SW_GNT_O && !SLV_GNT_O))
        else $error("Software did not win contention in mode 0.");

    AST_MODE1_SLV_WINS: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_02
        (both && ctl == `SPA_CTL_SW_DEM && s_q.cnt != 5'h00)
        |=> (SLV_GNT_O && !SW_GNT_O))
        else $error("Slave port did not win contention in mode 1.");

    AST_THRESH_HI_LOAD: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_03
        (both && ctl == `SPA_CTL_THRESH && s_q.cnt == 5'h00 && sw_hi)
        |=> (s_q.cnt == $past(init_val)))
        else $error("Counter not loaded with the initial value.");

    AST_THRESH_LO_LOAD: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_04
        (both && ctl == `SPA_CTL_THRESH && s_q.cnt == 5'h00 && !sw_hi)
        |=> (s_q.cnt == 5'h01 && SLV_GNT_O))
        else $error("Counter not loaded with one below threshold.");

    AST_EXTPIN_DECIDES: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_05
        (both && ctl == `SPA_CTL_EXTPIN)
        |=> (SLV_GNT_O == $past(EXT_SLV_PRI_I) && SW_GNT_O != SLV_GNT_O))
        else $error("External priority input not followed.");

    AST_EXTPIN_CNT_HOLD: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_06
        (both && ctl == `SPA_CTL_EXTPIN) |=> $stable(s_q.cnt))
        else $error("Counter moved while the external input decides.");

    AST_CNT_DECREMENT: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_18
        (both && ctl != `SPA_CTL_EXTPIN && s_q.cnt != 5'h00)
        |=> (s_q.cnt == $past(s_q.cnt) - 5'h01))
        else $error("Counter did not decrement on a favoured win.");

    AST_FAULT_CLEAR: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_15
        (wr_fault && FAULT_EV_I == 5'h00) |=> (s_q.flt == 5'h00))
        else $error("Fault flags not cleared by a write.");

    AST_FAULT_STICKY: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_17
        (FAULT_EV_I != 5'h00) |=> ((s_q.flt & $past(FAULT_EV_I)) == $past(FAULT_EV_I)))
        else $error("Fault pulse lost.");

    AST_MAIN_RESP: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_14
        FAULT_EV_I[`SPA_FLT_MAIN]
        |=> (s_q.fresp == $past(FAULT_RESP_I) && s_q.flt[`SPA_FLT_MAIN]))
        else $error("Main port fault response not recorded.");

    AST_BVALID_HOLD: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        (AXI_RSP_O.bvalid && !AXI_REQ_I.bready) |=> AXI_RSP_O.bvalid)
        else $error("Write response dropped before bready.");

    // A lone request never waits, whatever the mode or counter.
    AST_LONE_SW_GNT: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_01
        (SW_REQ_I && !SLV_REQ_I)
        |=> (SW_GNT_O && !SLV_GNT_O))
        else $error("Lone software request not granted.");

    AST_LONE_SLV_GNT: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_02
        (SLV_REQ_I && !SW_REQ_I)
        |=> (SLV_GNT_O && !SW_GNT_O))
        else $error("Lone slave port request not granted.");

    AST_MODE0_ZERO_DEMOTED: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_18
        (both && ctl == `SPA_CTL_SLV_DEM && s_q.cnt == 5'h00)
        |=> (SLV_GNT_O && !SW_GNT_O && s_q.cnt == $past(init_val)))
        else $error("Slave port not granted at counter zero in mode 0.");

    AST_MODE1_ZERO_DEMOTED: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_02
        (both && ctl == `SPA_CTL_SW_DEM && s_q.cnt == 5'h00)
        |=> (SW_GNT_O && !SLV_GNT_O && s_q.cnt == $past(init_val)))
        else $error("Software not granted at counter zero in mode 1.");

    AST_THRESH_SW_FAV: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_03
        (both && ctl == `SPA_CTL_THRESH && s_q.cnt != 5'h00)
        |=> (SW_GNT_O && !SLV_GNT_O))
        else $error("Software did not win contention in mode 2.");

    AST_FAULT_HOLD: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_15
        (!wr_fault && FAULT_EV_I == 5'h00)
        |=> $stable(s_q.flt))
        else $error("Fault flags changed without a pulse or a clear.");

    AST_IRQ_LEVEL: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_17
        IRQ_O == |(s_q.irq_pend & s_q.irq_msk))
        else $error("Interrupt level does not match unmasked status.");

    AST_CTRL_WRITE: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) // RULE_07
        (do_wr && s_q.awaddr == `SPA_OFS_CTRL && s_q.wstrb[1:0] == 2'h3)
        |=> (s_q.ctrl == $past(s_q.wdata[15:0])))
        else $error("Control register write not applied.");

endmodule

// file: dv/spa_slv_model.sv
/*
 * Behavioural master on the slave port: raises its request and its
 * external priority level as the bench commands.
 * Assumes one clock shared with the block and an active high reset.
 */
`timescale 1ns/1ps

module spa_slv_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic want_i,
    input wire logic pri_i,
    output logic slv_req_o,
    output logic ext_pri_o
);
    // ------------------------------------------------------------
    // Request and priority, changed only after a clock edge
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            slv_req_o <= 1'b0;
            ext_pri_o <= 1'b0;
        end else begin
            slv_req_o <= want_i;
            ext_pri_o <= pri_i;
        end
    end
endmodule

// file: dv/tb.sv
/*
 * Self-checking bench of the slave port arbiter and fault flags.
 * Assumes the design package, the register header and the model.
 */
`timescale 1ns/1ps
`include "spa_regs.svh"

module tb;
    import spa_pkg::*;
    `define CHK(nm, ex, ac) begin checked++; if ((ac) !== (ex)) begin err_count++; \
        $display("MISMATCH %s exp %0h got %0h", nm, ex, ac); end end

    logic clk = 1'b0;
    logic rst = 1'b1;
    spa_axil_req_type req = '0;
    spa_axil_rsp_type rsp;
    logic sw_req = 1'b0;
    logic want = 1'b0;
    logic pri = 1'b0;
    logic slv_req, ext_pri, sw_gnt, slv_gnt, irq;
    logic [7:0] exec_pri = 8'h00;
    logic [4:0] fault_ev = 5'h00;
    logic [1:0] fault_resp = 2'h0;
    logic [31:0] rd;
    logic [1:0] rs;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    logic [4:0] arb_init = 5'h03;

    spa_top u_spa_top (.SYS_CLK_I(clk), .RST_I(rst), .AXI_REQ_I(req), .AXI_RSP_O(rsp),
        .SW_REQ_I(sw_req), .SLV_REQ_I(slv_req), .EXEC_PRI_I(exec_pri),
        .EXT_SLV_PRI_I(ext_pri), .SW_GNT_O(sw_gnt), .SLV_GNT_O(slv_gnt),
        .FAULT_EV_I(fault_ev), .FAULT_RESP_I(fault_resp), .IRQ_O(irq));
    spa_slv_model u_spa_slv_model (.clk_i(clk), .rst_i(rst), .want_i(want), .pri_i(pri),
        .slv_req_o(slv_req), .ext_pri_o(ext_pri));

    initial begin
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Closing report and hang guard
    // ------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // Register bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        r = rsp.bresp;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        d = rsp.rdata;
        r = rsp.rresp;
    endtask

    // Contention over eight decisions is phase free: a reload period of
    // four (reload 3) or two (reload 1) always fits a whole number of times.
    task automatic arb(input logic [1:0] m, input logic [7:0] tp, input logic [7:0] ep,
                       input logic e, input logic both, input logic [3:0] es,
                       input logic [3:0] ev);
        logic [3:0] ns;
        logic [3:0] nv;
        ns = 4'h0;
        nv = 4'h0;
        wr(`SPA_OFS_CTRL, {16'h0, arb_init, 1'b0, tp, m}, rs);
        exec_pri <= ep;
        pri <= e;
        want <= 1'b1;
        sw_req <= both;
        repeat (4) @(posedge clk);
        repeat (8) begin
            @(posedge clk);
            ns = ns + {3'h0, sw_gnt};
            nv = nv + {3'h0, slv_gnt};
        end
        `CHK("sw grants", es, ns)
        `CHK("slave grants", ev, nv)
        want <= 1'b0;
        sw_req <= 1'b0;
        @(posedge clk);
    endtask

    task automatic fault(input logic [4:0] b, input logic [1:0] r);
        fault_ev <= b;
        fault_resp <= r;
        @(posedge clk);
        fault_ev <= 5'h00;
        @(posedge clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdr(`SPA_OFS_CTRL, rd, rs);
        `CHK("control reset", 32'h0000_0800, rd)
        rdr(`SPA_OFS_FAULT, rd, rs);
        `CHK("fault reset", 32'h0, rd)
        wr(`SPA_OFS_CTRL, 32'h0000_1d55, rs);
        rdr(`SPA_OFS_CTRL, rd, rs);
        `CHK("control rw", 32'h0000_1d55, rd)
        arb(2'h0, 8'h00, 8'h00, 1'b0, 1'b1, 4'h6, 4'h2);
        arb(2'h1, 8'h00, 8'h00, 1'b0, 1'b1, 4'h2, 4'h6);
        arb(2'h0, 8'h00, 8'h00, 1'b0, 1'b0, 4'h0, 4'h8);
        arb(2'h2, 8'h10, 8'h05, 1'b0, 1'b1, 4'h6, 4'h2);
        arb(2'h2, 8'h10, 8'h10, 1'b0, 1'b1, 4'h6, 4'h2);
        arb(2'h2, 8'h10, 8'h40, 1'b0, 1'b1, 4'h4, 4'h4);
        arb(2'h2, 8'hff, 8'hfe, 1'b0, 1'b1, 4'h6, 4'h2);
        arb(2'h2, 8'hff, 8'h00, 1'b0, 1'b1, 4'h4, 4'h4);
        arb(2'h2, 8'hfe, 8'hff, 1'b0, 1'b1, 4'h4, 4'h4);
        arb(2'h3, 8'h00, 8'h00, 1'b1, 1'b1, 4'h0, 4'h8);
        arb(2'h3, 8'h00, 8'h00, 1'b0, 1'b1, 4'h8, 4'h0);
        arb_init = 5'h01;
        arb(2'h0, 8'h00, 8'h00, 1'b0, 1'b1, 4'h4, 4'h4);
        fault(5'h01, 2'h0);
        `CHK("irq masked", 1'b0, irq)
        fault(5'h08, 2'h3);
        rdr(`SPA_OFS_FAULT, rd, rs);
        `CHK("fault main", 32'h0000_0309, rd)
        fault(5'h16, 2'h2);
        rdr(`SPA_OFS_FAULT, rd, rs);
        `CHK("fault all", 32'h0000_031f, rd)
        rdr(`SPA_OFS_IRQST, rd, rs);
        `CHK("irq status", 32'h0000_001f, rd)
        wr(`SPA_OFS_IRQMSK, 32'h0000_0010, rs);
        repeat (2) @(posedge clk);
        `CHK("irq raised", 1'b1, irq)
        wr(`SPA_OFS_IRQST, 32'h0000_0010, rs);
        repeat (2) @(posedge clk);
        `CHK("irq cleared", 1'b0, irq)
        wr(`SPA_OFS_FAULT, 32'h0, rs);
        rdr(`SPA_OFS_FAULT, rd, rs);
        `CHK("fault clear", 5'h00, rd[4:0])
        rdr(8'h10, rd, rs);
        `CHK("unmapped read", `SPA_RESP_SLVERR, rs)
        wr(8'h14, 32'h1, rs);
        `CHK("unmapped write", `SPA_RESP_SLVERR, rs)
        test_done();
    end
endmodule
